// *** core/sdc_chan_mem.v ***
// two-entry per-channel store, registered read port
`timescale 1ns/1ns
module sdc_chan_mem (
    input wire sys_clk,
    input wire srst,
    input wire wr_en,
    input wire wr_addr,
    input wire [20:0] wr_data,
    input wire rd_addr,
    input wire [20:0] rst_val,
    output reg [20:0] rd_data,
    output wire [41:0] all_data
);
reg [20:0] mem_q [0:1];
assign all_data = {mem_q[1], mem_q[0]};
always @(posedge sys_clk)
begin
    if (srst)
    begin
        mem_q[0] <= rst_val;
        mem_q[1] <= rst_val;
        rd_data <= rst_val;
    end
    else
    begin
        if (wr_en)
            mem_q[wr_addr] <= wr_data;
        // read data lags by one cycle; host frame slack covers it
        rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem_q[rd_addr];
    end
end
endmodule // sdc_chan_mem

// *** core/sdc_ctrl.v ***
// solenoid driver control register set with dividers and stage gating
// Summary of operation
// RQ1 - bit 31 writes; reads return it zero
// RQ2 - watchdog supervises clock only when enabled
// RQ3 - stages off until watchdog enable once set
// RQ4 - dither clock is sys/((M+1)*2^N)
// RQ5 - divider code selects clock division 8/6/4/2
// RQ6 - first divider write starts autozero
// RQ7 - outputs disabled until divider written
// RQ8 - calibration mode only while bit 23 set
// RQ9 - calibration codes drive fets directly
// RQ10 - setpoint write targets selected channel only
// RQ11 - channel enable refused before diagnosis read
// RQ12 - autolimit bit, default on, limit 20
// RQ13 - dither enable per channel, default off
// RQ14 - sync bit aligns dither to pwm
// RQ15 - feedback mode bit selects report content
// RQ16 - steps field counts quarter-wave steps
// RQ17 - host keeps steps times size within 1023
// RQ18 - read frames change nothing, return contents; a diagnosis read sets diag_read_q and gets no answer here
`timescale 1ns/1ns
`include "sdc_regs.vh"
module sdc_ctrl (
    input wire sys_clk,
    input wire srst,
    input wire frame_valid,
    input wire [31:0] frame_in,
    input wire ext_clk_tick,
    input wire wd_timeout,
    input wire [1:0] pwm_start,
    output reg [31:0] frame_out,
    output reg frame_out_valid,
    output reg sys_tick,
    output reg dither_tick,
    output reg autozero_start,
    output reg watchdog_active,
    output reg outputs_enabled,
    output reg [1:0] hs_on,
    output reg [1:0] ls_on,
    output reg cal_mode,
    output reg [1:0] ch_enable,
    output reg [21:0] ch_setpoint,
    output reg [1:0] ch_autolimit,
    output reg [7:0] autolimit_value,
    output reg [1:0] dither_enable,
    output reg [1:0] dither_sync,
    output reg [1:0] cfb_select,
    output reg [11:0] dither_steps,
    output reg [11:0] dither_step_size,
    output reg [1:0] dither_start
);
reg [31:0] clkdiv_q;
reg [31:0] cal_q;
reg div_written_q;
reg clock_watchdog_enable_seen_q;
reg diag_read_q;
reg [2:0] fdiv_cnt_q;
reg [6:0] mant_cnt_q;
reg [15:0] exp_cnt_q;
reg rd_pend_q;
reg [4:0] rd_code_q;
reg [1:0] rd_ch_q;
wire rw = frame_in[`SDC_RW_BIT];
wire [4:0] code = frame_in[`SDC_CODE_HI:`SDC_CODE_LO];
wire [1:0] ch = frame_in[`SDC_CH_HI:`SDC_CH_LO];
wire ch_ok = (ch == `SDC_CH_ONE) || (ch == `SDC_CH_TWO);
wire ch_idx = (ch == `SDC_CH_TWO);
// divider and diagnosis registers share code 0; the channel bits tell them apart
wire is_diag = frame_in[30:24] == `SDC_DIAG_ID;
wire wr_clk = frame_valid && rw && frame_in[30:24] == `SDC_ID_CLKDIV;
wire wr_cal = frame_valid && rw && frame_in[30:24] == `SDC_ID_CAL;
wire wr_sp = frame_valid && rw && code == `SDC_CODE_SETPT && ch_ok;
wire wr_dt = frame_valid && rw && code == `SDC_CODE_DITHER && ch_ok;
// watchdog fault holds stages off only while supervision is on
wire stage_ok = div_written_q && clock_watchdog_enable_seen_q && !(clkdiv_q[`SDC_CLOCK_WATCHDOG_ENABLE_BIT] && wd_timeout);
wire [20:0] sp_rd;
wire [20:0] dt_rd;
wire [41:0] sp_all;
wire [41:0] dt_all;
// stored per-channel word: {en/dith_en, al/sync, cfb, steps, size/setpoint}
wire [20:0] sp_old = ch_idx ? sp_all[41:21] : sp_all[20:0];
// enable refused until diagnosis read; keep old enable instead
wire sp_en = frame_in[`SDC_EN_BIT] & (diag_read_q | sp_old[20]); // RQ11
wire [20:0] sp_wdata = {sp_en, frame_in[`SDC_AL_BIT], 8'h00,
    frame_in[`SDC_SP_HI:`SDC_SP_LO]}; // RQ10 RQ12
wire [20:0] dt_wdata = {frame_in[`SDC_EN_BIT], frame_in[`SDC_SYNC_BIT],
    frame_in[`SDC_CFB_BIT], frame_in[`SDC_STEPS_HI:`SDC_STEPS_LO], 6'h00,
    frame_in[`SDC_SSZ_HI:`SDC_SSZ_LO]}; // RQ13 RQ14 RQ15 RQ16

// divide ratio from code: 00->8, 01->6, 10->4, 11->2
function [2:0] fdiv_top;
    input [1:0] c;
    begin
        case (c)
            2'h0: fdiv_top = 3'h7;
            2'h1: fdiv_top = 3'h5;
            2'h2: fdiv_top = 3'h3;
            default: fdiv_top = 3'h1;
        endcase
    end
endfunction

// calibration code to {hs, ls}; 00 and 11 both off
function [1:0] cal_fets;
    input [1:0] c;
    begin
        case (c)
            2'h1: cal_fets = 2'b01;
            2'h2: cal_fets = 2'b10;
            default: cal_fets = 2'b00;
        endcase
    end
endfunction

sdc_chan_mem u_sp (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(wr_sp),
    .wr_addr(ch_idx),
    .wr_data(sp_wdata),
    .rd_addr(ch_idx),
    .rst_val(21'h080000),
    .rd_data(sp_rd),
    .all_data(sp_all)
);

sdc_chan_mem u_dt (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(wr_dt),
    .wr_addr(ch_idx),
    .wr_data(dt_wdata),
    .rd_addr(ch_idx),
    .rst_val(21'h000000),
    .rd_data(dt_rd),
    .all_data(dt_all)
);

always @(posedge sys_clk)
begin
    if (srst)
    begin
        clkdiv_q <= `SDC_CLKDIV_RESET;
        cal_q <= `SDC_CAL_RESET;
        div_written_q <= 1'b0;
        clock_watchdog_enable_seen_q <= 1'b0;
        diag_read_q <= 1'b0;
        autozero_start <= 1'b0;
    end
    else
    begin
        autozero_start <= 1'b0;
        if (wr_clk)
        begin
            clkdiv_q[12:0] <= frame_in[12:0];
            div_written_q <= 1'b1; // RQ7
            if (!div_written_q)
                autozero_start <= 1'b1; // RQ6
            if (frame_in[`SDC_CLOCK_WATCHDOG_ENABLE_BIT])
                clock_watchdog_enable_seen_q <= 1'b1; // RQ3
        end
        if (wr_cal)
        begin
            cal_q[`SDC_CM_BIT] <= frame_in[`SDC_CM_BIT]; // RQ8
            cal_q[5:2] <= frame_in[5:2];
        end
        if (frame_valid && is_diag)
            diag_read_q <= 1'b1; // RQ11
    end
end

// external clock prescaler to system rate
always @(posedge sys_clk)
begin
    if (srst)
    begin
        fdiv_cnt_q <= 3'h0;
        sys_tick <= 1'b0;
    end
    else
    begin
        sys_tick <= 1'b0;
        if (ext_clk_tick)
        begin
            if (fdiv_cnt_q >= fdiv_top(clkdiv_q[`SDC_FDIV_HI:`SDC_FDIV_LO])) // RQ5
            begin
                fdiv_cnt_q <= 3'h0;
                sys_tick <= 1'b1;
            end
            else
                fdiv_cnt_q <= fdiv_cnt_q + 3'h1;
        end
    end
end

// dither step pre-divider: (M+1) stage then 2^N stage
always @(posedge sys_clk)
begin
    if (srst)
    begin
        mant_cnt_q <= 7'h00;
        exp_cnt_q <= 16'h0000;
        dither_tick <= 1'b0;
    end
    else
    begin
        dither_tick <= 1'b0;
        if (sys_tick)
        begin
            if (mant_cnt_q >= {1'b0, clkdiv_q[`SDC_MANT_HI:`SDC_MANT_LO]}) // RQ4
            begin
                mant_cnt_q <= 7'h00;
                if (exp_cnt_q >= (16'hFFFF >> (5'h10 - {1'b0, clkdiv_q[5:2]}))) // RQ4
                begin
                    exp_cnt_q <= 16'h0000;
                    dither_tick <= 1'b1;
                end
                else
                    exp_cnt_q <= exp_cnt_q + 16'h0001;
            end
            else
                mant_cnt_q <= mant_cnt_q + 7'h01;
        end
    end
end

// pending read answered one cycle later from registered store
always @(posedge sys_clk)
begin
    if (srst)
    begin
        rd_pend_q <= 1'b0;
        rd_code_q <= 5'h00;
        rd_ch_q <= 2'h0;
        frame_out <= 32'h00000000;
        frame_out_valid <= 1'b0;
    end
    else
    begin
        rd_pend_q <= frame_valid && !rw && !is_diag; // RQ18
        rd_code_q <= code;
        rd_ch_q <= ch;
        frame_out_valid <= rd_pend_q;
        if (rd_pend_q)
        begin
            case (rd_code_q)
                `SDC_CODE_CLKDIV: frame_out <= ({rd_code_q, rd_ch_q} == `SDC_ID_CLKDIV) ?
                    {1'b0, clkdiv_q[30:0]} : 32'h00000000; // RQ1
                `SDC_CODE_CAL: frame_out <= ({rd_code_q, rd_ch_q} == `SDC_ID_CAL) ?
                    {1'b0, cal_q[30:0]} : 32'h00000000; // RQ1
                `SDC_CODE_SETPT: frame_out <= {1'b0, rd_code_q, rd_ch_q,
                    sp_rd[20:19], 11'h000, sp_rd[10:0]}; // RQ18
                `SDC_CODE_DITHER: frame_out <= {1'b0, rd_code_q, rd_ch_q,
                    dt_rd[20:18], 5'h00, dt_rd[17:12], 4'h0, dt_rd[5:0]}; // RQ18
                default: frame_out <= 32'h00000000;
            endcase
        end
    end
end

// output stage gating and per-channel fan-out
always @(posedge sys_clk)
begin
    if (srst)
    begin
        watchdog_active <= 1'b0;
        outputs_enabled <= 1'b0;
        cal_mode <= 1'b0;
        hs_on <= 2'b00;
        ls_on <= 2'b00;
        ch_enable <= 2'b00;
        ch_setpoint <= 22'h000000;
        ch_autolimit <= 2'b11;
        autolimit_value <= `SDC_AUTOLIMIT;
        dither_enable <= 2'b00;
        dither_sync <= 2'b00;
        cfb_select <= 2'b00;
        dither_steps <= 12'h000;
        dither_step_size <= 12'h000;
        dither_start <= 2'b00;
    end
    else
    begin
        watchdog_active <= clkdiv_q[`SDC_CLOCK_WATCHDOG_ENABLE_BIT] && !wd_timeout; // RQ2
        outputs_enabled <= stage_ok; // RQ3 RQ7
        cal_mode <= cal_q[`SDC_CM_BIT]; // RQ8
        if (stage_ok && cal_q[`SDC_CM_BIT])
        begin
            {hs_on[1], ls_on[1]} <= cal_fets(cal_q[`SDC_SECOND_STAGE_OVERRIDE_HI:`SDC_SECOND_STAGE_OVERRIDE_LO]); // RQ9
            {hs_on[0], ls_on[0]} <= cal_fets(cal_q[`SDC_FIRST_STAGE_OVERRIDE_HI:`SDC_FIRST_STAGE_OVERRIDE_LO]); // RQ9
        end
        else
        begin
            hs_on <= 2'b00;
            ls_on <= 2'b00;
        end
        ch_enable <= {sp_all[41], sp_all[20]} & {2{stage_ok}}; // RQ3 RQ7
        ch_setpoint <= {sp_all[31:21], sp_all[10:0]};
        ch_autolimit <= {sp_all[40], sp_all[19]}; // RQ12
        dither_enable <= {dt_all[41], dt_all[20]}; // RQ13
        dither_sync <= {dt_all[40], dt_all[19]};
        cfb_select <= {dt_all[39], dt_all[18]}; // RQ15
        dither_steps <= {dt_all[38:33], dt_all[17:12]}; // RQ16
        dither_step_size <= {dt_all[26:21], dt_all[5:0]}; // RQ17
        // sync: step only at pwm start, else free on the step clock
        dither_start[0] <= dt_all[20] && (dt_all[19] ? pwm_start[0] : dither_tick); // RQ14
        dither_start[1] <= dt_all[41] && (dt_all[40] ? pwm_start[1] : dither_tick); // RQ14
    end
end
endmodule // sdc_ctrl

// *** core/sdc_regs.vh ***
// register codes, field positions, reset values and timing counts
`ifndef SDC_REGS_VH
`define SDC_REGS_VH
`define SDC_RW_BIT 31
`define SDC_CODE_HI 30
`define SDC_CODE_LO 26
`define SDC_CH_HI 25
`define SDC_CH_LO 24
`define SDC_CODE_CLKDIV 5'h00
`define SDC_CODE_CAL 5'h01
`define SDC_CODE_SETPT 5'h04
`define SDC_CODE_DITHER 5'h06
`define SDC_CODE_DIAG 5'h00
`define SDC_DIAG_ID 7'h02
`define SDC_ID_CLKDIV 7'h03
`define SDC_ID_CAL 7'h05
`define SDC_CH_ONE 2'h1
`define SDC_CH_TWO 2'h2
`define SDC_CLKDIV_RESET 32'h03000818
`define SDC_CAL_RESET 32'h05000000
`define SDC_CLOCK_WATCHDOG_ENABLE_BIT 12
`define SDC_MANT_HI 11
`define SDC_MANT_LO 6
`define SDC_EXP_HI 5
`define SDC_EXP_LO 2
`define SDC_FDIV_HI 1
`define SDC_FDIV_LO 0
`define SDC_MANT_RESET 6'h20
`define SDC_EXP_RESET 4'h6
`define SDC_FDIV_RESET 2'h0
`define SDC_CM_BIT 23
`define SDC_SECOND_STAGE_OVERRIDE_HI 5
`define SDC_SECOND_STAGE_OVERRIDE_LO 4
`define SDC_FIRST_STAGE_OVERRIDE_HI 3
`define SDC_FIRST_STAGE_OVERRIDE_LO 2
`define SDC_EN_BIT 23
`define SDC_AL_BIT 22
`define SDC_SP_HI 10
`define SDC_SP_LO 0
`define SDC_SYNC_BIT 22
`define SDC_CFB_BIT 21
`define SDC_STEPS_HI 15
`define SDC_STEPS_LO 10
`define SDC_SSZ_HI 5
`define SDC_SSZ_LO 0
`define SDC_AUTOLIMIT 8'h14
`define SDC_CHREG_W 21
`endif

// *** dv/sdc_ctrl_props.sv ***
// port assertions for the control register set
`timescale 1ns/1ns
module sdc_ctrl_props (
    input wire sys_clk,
    input wire srst,
    input wire frame_valid,
    input wire [31:0] frame_in,
    input wire wd_timeout,
    input wire [31:0] frame_out,
    input wire frame_out_valid,
    input wire autozero_start,
    input wire watchdog_active,
    input wire outputs_enabled,
    input wire [1:0] hs_on,
    input wire [1:0] ls_on,
    input wire cal_mode,
    input wire [1:0] ch_enable,
    input wire [7:0] autolimit_value
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // diagnosis reads are answered outside this block
    wire rd_req = frame_valid && !frame_in[31] && frame_in[30:24] != 7'h02;
    wire wr_div = frame_valid && frame_in[31] && frame_in[30:24] == 7'h03;
    reg seen_q;
    always @(posedge sys_clk)
        if (srst)
            seen_q <= 1'b0;
        else if (autozero_start)
            seen_q <= 1'b1;
    a_read_answer: assert property (rd_req |-> ##2 frame_out_valid)
        else $error("read frame got no answer");
    a_read_caused: assert property (frame_out_valid |-> $past(rd_req, 2))
        else $error("answer without read frame");
    a_read_bit_zero: assert property (frame_out_valid |-> !frame_out[31])
        else $error("read answer bit 31 set");
    a_az_cause: assert property (autozero_start |-> $past(wr_div) || $past(wr_div, 2))
        else $error("autozero without divider write");
    a_az_once: assert property (autozero_start |-> !seen_q)
        else $error("autozero started twice");
    a_cal_off: assert property (!cal_mode |-> (hs_on | ls_on) == 2'h0)
        else $error("stage driven outside calibration");
    a_fet_split: assert property ((hs_on & ls_on) == 2'h0)
        else $error("both transistors on");
    a_gate_off: assert property (!outputs_enabled && $past(!outputs_enabled) |->
        ch_enable == 2'h0 && (hs_on | ls_on) == 2'h0)
        else $error("output active while gated");
    a_wd_fault: assert property (wd_timeout && $past(wd_timeout) |-> !watchdog_active)
        else $error("watchdog active during fault");
    a_limit_value: assert property (autolimit_value == 8'h14)
        else $error("autolimit value wrong");
    c_read: cover property (rd_req ##2 frame_out_valid);
    c_az: cover property (autozero_start);
    c_cal: cover property (cal_mode && hs_on != 2'h0);
endmodule // sdc_ctrl_props
bind sdc_ctrl sdc_ctrl_props sdc_ctrl_props_i (.sys_clk, .srst, .frame_valid, .frame_in,
    .wd_timeout, .frame_out, .frame_out_valid, .autozero_start, .watchdog_active,
    .outputs_enabled, .hs_on, .ls_on, .cal_mode, .ch_enable, .autolimit_value);

// *** dv/sdc_ctrl_test.sv ***
// self-checking testbench for the control register set
`timescale 1ns/1ns
module sdc_ctrl_test;
    reg sys_clk = 1'b0;
    reg srst = 1'b1;
    reg ext_clk_tick = 1'b0;
    reg wd_timeout = 1'b0;
    reg [1:0] pwm_start = 2'h0;
    wire frame_valid, frame_out_valid, sys_tick, dither_tick, autozero_start;
    wire watchdog_active, outputs_enabled, cal_mode;
    wire [31:0] frame_in, frame_out;
    wire [1:0] hs_on, ls_on, ch_enable, ch_autolimit, dither_enable, dither_sync, cfb_select;
    wire [1:0] dither_start;
    wire [21:0] ch_setpoint;
    wire [7:0] autolimit_value;
    wire [11:0] dither_steps, dither_step_size;
    integer fail_count = 0;
    integer total_checks = 0;
    integer az_count = 0;
    integer i;
    reg [31:0] r;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (autozero_start === 1'b1)
            az_count = az_count + 1;
    sdc_host sdc_host_i (.sys_clk(sys_clk), .frame_valid(frame_valid), .frame_in(frame_in),
        .frame_out(frame_out), .frame_out_valid(frame_out_valid));
    sdc_ctrl sdc_ctrl_i (.sys_clk(sys_clk), .srst(srst), .frame_valid(frame_valid),
        .frame_in(frame_in), .ext_clk_tick(ext_clk_tick), .wd_timeout(wd_timeout),
        .pwm_start(pwm_start), .frame_out(frame_out), .frame_out_valid(frame_out_valid),
        .sys_tick(sys_tick), .dither_tick(dither_tick), .autozero_start(autozero_start),
        .watchdog_active(watchdog_active), .outputs_enabled(outputs_enabled),
        .hs_on(hs_on), .ls_on(ls_on), .cal_mode(cal_mode), .ch_enable(ch_enable),
        .ch_setpoint(ch_setpoint), .ch_autolimit(ch_autolimit),
        .autolimit_value(autolimit_value), .dither_enable(dither_enable),
        .dither_sync(dither_sync), .cfb_select(cfb_select), .dither_steps(dither_steps),
        .dither_step_size(dither_step_size), .dither_start(dither_start));
    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    end
    endtask
    task rd(input [31:0] f, input [31:0] exp);
    begin
        sdc_host_i.xfer(f, r);
        chk(r, exp);
    end
    endtask
    task wr(input [31:0] f);
    begin
        sdc_host_i.xfer(f, r);
        repeat (2) @(posedge sys_clk);
        #1;
    end
    endtask
    // cycles between pulses; the first gap after a change may mix old and new ratios
    task per(input sel, input integer exp);
        integer n, k;
    begin
        for (k = 0; k < 3; k = k + 1)
        begin
            n = 0;
            do
            begin
                @(posedge sys_clk);
                #1;
                n = n + 1;
            end
            while ((sel ? dither_tick : sys_tick) !== 1'b1 && n < 20000);
        end
        chk(n, exp);
    end
    endtask
    task t_reset;
    begin
        rd(32'h03000000, 32'h03000818);
        rd(32'h05000000, 32'h05000000);
        rd(32'h11000000, 32'h11400000);
        rd(32'h1A000000, 32'h1A000000);
        chk({watchdog_active, outputs_enabled, ch_autolimit, autolimit_value}, 32'h314);
    end
    endtask
    task t_gate;
    begin
        wr(32'h83000818);
        chk(outputs_enabled, 32'h0);
        wr(32'h83001818);
        chk({watchdog_active, outputs_enabled}, 32'h3);
        wr(32'h83000818);
        chk({watchdog_active, outputs_enabled}, 32'h1);
        chk(az_count, 32'h1);
    end
    endtask
    task t_div;
    begin
        wr(32'h8300081B);
        per(1'b1, 4224);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(32'h83000044 | i);
            per(1'b0, 8 - 2 * i);
            per(1'b1, 4 * (8 - 2 * i));
        end
    end
    endtask
    task t_setpt;
    begin
        wr(32'h91800155);
        rd(32'h11000000, 32'h11000155);
        sdc_host_i.xfer(32'h02000000, r);
        wr(32'h92C007FF);
        wr(32'h93000000);
        rd(32'h12000000, 32'h12C007FF);
        chk({ch_enable, ch_autolimit, ch_setpoint}, {2'h2, 2'h2, 11'h7FF, 11'h155});
    end
    endtask
    task t_cal;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(32'h85800000 | ((3 - i) << 4) | (i << 2));
            chk({cal_mode, hs_on, ls_on}, {1'b1, i == 1, i == 2, i == 2, i == 1});
        end
        wr(32'h85000028);
        chk({cal_mode, hs_on, ls_on}, 32'h0);
        rd(32'h05000000, 32'h05000028);
    end
    endtask
    task t_dither;
    begin
        wr(32'h9AA00C05);
        wr(32'h99400000);
        chk({dither_enable, dither_sync, cfb_select, dither_steps, dither_step_size},
            {2'h2, 2'h1, 2'h2, 6'h3, 6'h0, 6'h5, 6'h0});
        rd(32'h1A000000, 32'h1AA00C05);
        // synced channel starts on its pwm pulse and is low again one cycle later
        wr(32'h99C00000);
        pwm_start = 2'h1;
        @(posedge sys_clk);
        #1;
        pwm_start = 2'h0;
        chk(dither_start[0], 32'h1);
        @(posedge sys_clk);
        #1;
        chk(dither_start[0], 32'h0);
    end
    endtask
    task t_wdog;
    begin
        wr(32'h83001818);
        chk(watchdog_active, 32'h1);
        wd_timeout = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({watchdog_active, outputs_enabled, ch_enable}, 32'h0);
    end
    endtask
    task test_done;
    begin
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    initial
    begin
        #600000;
        fail_count = fail_count + 1;
        test_done;
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        ext_clk_tick = 1'b1;
        t_reset;
        t_gate;
        t_div;
        t_setpt;
        t_cal;
        t_dither;
        t_wdog;
        test_done;
    end
endmodule // sdc_ctrl_test

// *** dv/sdc_host.sv ***
// host model issuing register frames
`timescale 1ns/1ns
module sdc_host (
    input wire sys_clk,
    output reg frame_valid,
    output reg [31:0] frame_in,
    input wire [31:0] frame_out,
    input wire frame_out_valid
);
    initial
    begin
        frame_valid = 1'b0;
        frame_in = 32'h0;
    end
    // one frame per call; answer taken while its valid pulse stands
    task xfer(input [31:0] f, output [31:0] r);
    begin
        @(posedge sys_clk);
        #1;
        frame_valid = 1'b1;
        frame_in = f;
        @(posedge sys_clk);
        #1;
        frame_valid = 1'b0;
        // idle bus inverted so a stale frame cannot look valid
        frame_in = ~f;
        @(posedge sys_clk);
        #1;
        r = (frame_out_valid === 1'b1) ? frame_out : 32'hXXXXXXXX;
    end
    endtask
endmodule // sdc_host
